// ==== src/alsu_cfg.svh ====
// Constants of the arithmetic, logic and shift unit
// Operation
// - Add/subtract registers; add immediate to register
// - No immediate form of plain subtract
// - Word add/subtract only between two registers
// - Byte add/subtract including carry or borrow
// - Byte step up or down by one
// - Word step up or down by one/two
// - Decimal fix of byte using condition flags
// - Unsigned 8x8 multiply giving 16-bit product
// - Unsigned 16/8 divide, quotient and remainder
// - Compare subtracts, updates flags, stores nothing
// - Word compare only between two registers
// - Negate byte: zero minus contents
// - Bitwise AND with register or immediate
// - Bitwise OR with register or immediate
// - Bitwise XOR with register or immediate
// - Invert every bit of byte
// - Arithmetic shift by one, right keeps sign
// - Logical shift by one, zero fill
// - Rotate byte by one position
// - Rotate byte through carry, nine-bit ring
// - Flags: negative, zero, overflow, carry, half carry
`ifndef ALSU_CFG_SVH
`define ALSU_CFG_SVH

// Flag bit positions inside the condition flags
`define ALSU_FLAG_C 0
`define ALSU_FLAG_V 1
`define ALSU_FLAG_Z 2
`define ALSU_FLAG_N 3
`define ALSU_FLAG_H 4
`define ALSU_FLAG_W 5
`define ALSU_FLAGS_RST 5'h00

// Register offsets on the software port
`define ALSU_ADDR_W 2
`define ALSU_OFS_FLAGS 2'h0
`define ALSU_OFS_STATUS 2'h1

// Status register fields
`define ALSU_STAT_ILLEGAL 0
`define ALSU_STAT_DIVERR 1
`define ALSU_STAT_RST 2'h0

`endif

// ==== src/alsu_pkg.sv ====
// Types of the arithmetic, logic and shift unit
package alsu_pkg;
	typedef enum logic [4:0] {
		op_sum, op_difference, op_sum_with_carry, op_difference_with_borrow,
		op_step_up, op_step_down, op_sum_one_or_two, op_difference_one_or_two,
		op_decimal_fix_after_sum, op_decimal_fix_after_difference,
		op_unsigned_multiply, op_unsigned_divide, op_compare, op_twos_complement,
		op_conjunction, op_disjunction, op_exclusive_disjunction, op_invert,
		op_arith_shift_left, op_arith_shift_right, op_logic_shift_left,
		op_logic_shift_right, op_circular_left, op_circular_right,
		op_carry_circular_left, op_carry_circular_right
	} alsu_op_t;
endpackage

// ==== src/alsu_unit.sv ====
// Arithmetic, logic and shift datapath with condition flags
`include "alsu_cfg.svh"

module alsu_unit
	import alsu_pkg::*;
(
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    arst_n,
	// Operation request from the decoder
	input  wire logic                    op_valid,
	input  wire alsu_op_t                op_code,
	input  wire logic                    op_word,
	input  wire logic                    op_imm,
	input  wire logic                    op_step_two,
	input  wire logic [15:0]             dst_val,
	input  wire logic [15:0]             src_val,
	input  wire logic [7:0]              imm_val,
	// Result toward the register file
	output logic                         res_valid,
	output logic                         res_write,
	output logic                         res_word,
	output logic [15:0]                  res_data,
	output logic                         op_illegal,
	output logic [4:0]                   cond_flags,
	// Software register port
	input  wire logic [`ALSU_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [7:0]                   reg_rdata
);

	logic [4:0]  flags_q, flags_d;
	logic [1:0]  stat_q;
	logic        res_valid_q, res_write_q, res_word_q, illegal_q;
	logic [15:0] res_q;
	logic [7:0]  rdata_q;
	logic        wr_d, word_d, illegal_d, diverr_d;
	logic [15:0] res_d;
	logic [7:0]  a8, b8, ba, bb, bbe;
	logic        bc, bsub, bcy, bh, bv, cin;
	logic [8:0]  s9;
	logic [4:0]  hs;
	logic [15:0] wb, wbe;
	logic        wsub, wcy, wv;
	logic [16:0] s17;
	logic [15:0] quo;
	logic [7:0]  rem;
	logic [7:0]  adj;

	assign a8  = dst_val[7:0];
	assign b8  = op_imm ? imm_val : src_val[7:0];
	assign cin = flags_q[`ALSU_FLAG_C];

	// Byte adder operand steering
	always_comb begin
		ba   = a8;
		bb   = b8;
		bc   = 1'b0;
		bsub = 1'b0;
		case (op_code)
			op_difference, op_compare: bsub = 1'b1;
			op_sum_with_carry: bc = cin;
			op_difference_with_borrow: begin
				bc   = cin;
				bsub = 1'b1;
			end
			op_step_up: bb = 8'h01;
			op_step_down: begin
				bb   = 8'h01;
				bsub = 1'b1;
			end
			op_twos_complement: begin
				ba   = 8'h00;
				bb   = a8;
				bsub = 1'b1;
			end
			default: bsub = 1'b0;
		endcase
	end

	// Subtract as add of inverse, so one carry chain serves both
	assign bbe = bsub ? ~bb : bb;
	assign s9  = {1'b0, ba} + {1'b0, bbe} + {8'h00, bc ^ bsub};
	assign hs  = {1'b0, ba[3:0]} + {1'b0, bbe[3:0]} + {4'h0, bc ^ bsub};
	assign bcy = s9[8] ^ bsub;
	assign bh  = hs[4] ^ bsub;
	assign bv  = (ba[7] == bbe[7]) && (s9[7] != ba[7]);

	// Word adder for register pairs and pointer steps
	always_comb begin
		wb   = src_val;
		wsub = 1'b0;
		case (op_code)
			op_difference, op_compare: wsub = 1'b1;
			op_sum_one_or_two: wb = op_step_two ? 16'h0002 : 16'h0001;
			op_difference_one_or_two: begin
				wb   = op_step_two ? 16'h0002 : 16'h0001;
				wsub = 1'b1;
			end
			default: wsub = 1'b0;
		endcase
	end

	assign wbe = wsub ? ~wb : wb;
	assign s17 = {1'b0, dst_val} + {1'b0, wbe} + {16'h0000, wsub};
	assign wcy = s17[16] ^ wsub;
	assign wv  = (dst_val[15] == wbe[15]) && (s17[15] != dst_val[15]);

	// Divider kept combinational; the slow path limits the clock, not the cycle count
	assign quo = (src_val[7:0] == 8'h00) ? 16'hffff : dst_val / {8'h00, src_val[7:0]};
	assign rem = (src_val[7:0] == 8'h00) ? 8'h00 : 8'((dst_val % {8'h00, src_val[7:0]}));

	// Result and flag selection
	always_comb begin
		res_d     = 16'h0000;
		wr_d      = 1'b1;
		word_d    = 1'b0;
		illegal_d = 1'b0;
		diverr_d  = 1'b0;
		flags_d   = flags_q;
		adj       = 8'h00;
		case (op_code)
			op_sum, op_difference, op_compare: begin
				if (op_word && op_imm) begin
					illegal_d = 1'b1;
				end else if (op_imm && op_code == op_difference) begin
					illegal_d = 1'b1;
				end else if (op_word) begin
					res_d  = s17[15:0];
					word_d = 1'b1;
					flags_d[`ALSU_FLAG_C] = wcy;
					flags_d[`ALSU_FLAG_V] = wv;
				end else begin
					res_d = {8'h00, s9[7:0]};
					flags_d[`ALSU_FLAG_C] = bcy;
					flags_d[`ALSU_FLAG_V] = bv;
					flags_d[`ALSU_FLAG_H] = bh;
				end
				if (op_code == op_compare) begin
					wr_d = 1'b0;
				end
			end
			op_sum_with_carry, op_difference_with_borrow, op_twos_complement: begin
				res_d = {8'h00, s9[7:0]};
				flags_d[`ALSU_FLAG_C] = bcy;
				flags_d[`ALSU_FLAG_V] = bv;
				flags_d[`ALSU_FLAG_H] = bh;
			end
			op_step_up, op_step_down: begin
				res_d = {8'h00, s9[7:0]};
				flags_d[`ALSU_FLAG_V] = bv;
			end
			op_sum_one_or_two, op_difference_one_or_two: begin
				res_d  = s17[15:0];
				word_d = 1'b1;
			end
			op_decimal_fix_after_sum: begin
				if (flags_q[`ALSU_FLAG_H] || a8[3:0] > 4'h9) begin
					adj[3:0] = 4'h6;
				end
				if (cin || a8 > 8'h99) begin
					adj[7:4] = 4'h6;
					flags_d[`ALSU_FLAG_C] = 1'b1;
				end
				res_d = {8'h00, a8 + adj};
			end
			op_decimal_fix_after_difference: begin
				adj   = {cin ? 4'h6 : 4'h0, flags_q[`ALSU_FLAG_H] ? 4'h6 : 4'h0};
				res_d = {8'h00, a8 - adj};
			end
			op_unsigned_multiply: begin
				res_d  = {8'h00, a8} * {8'h00, src_val[7:0]};
				word_d = 1'b1;
			end
			op_unsigned_divide: begin
				word_d = 1'b1;
				if (quo[15:8] != 8'h00) begin
					// Zero divisor or quotient overflow leaves the register alone
					wr_d     = 1'b0;
					diverr_d = 1'b1;
					flags_d[`ALSU_FLAG_V] = 1'b1;
				end else begin
					res_d = {rem, quo[7:0]};
					flags_d[`ALSU_FLAG_V] = 1'b0;
				end
			end
			op_conjunction: res_d = {8'h00, a8 & b8};
			op_disjunction: res_d = {8'h00, a8 | b8};
			op_exclusive_disjunction: res_d = {8'h00, a8 ^ b8};
			op_invert: res_d = {8'h00, ~a8};
			op_arith_shift_left, op_logic_shift_left: begin
				res_d = {8'h00, a8[6:0], 1'b0};
				flags_d[`ALSU_FLAG_C] = a8[7];
			end
			op_arith_shift_right: begin
				res_d = {8'h00, a8[7], a8[7:1]};
				flags_d[`ALSU_FLAG_C] = a8[0];
			end
			op_logic_shift_right: begin
				res_d = {8'h00, 1'b0, a8[7:1]};
				flags_d[`ALSU_FLAG_C] = a8[0];
			end
			op_circular_left: begin
				res_d = {8'h00, a8[6:0], a8[7]};
				flags_d[`ALSU_FLAG_C] = a8[7];
			end
			op_circular_right: begin
				res_d = {8'h00, a8[0], a8[7:1]};
				flags_d[`ALSU_FLAG_C] = a8[0];
			end
			op_carry_circular_left: begin
				res_d = {8'h00, a8[6:0], cin};
				flags_d[`ALSU_FLAG_C] = a8[7];
			end
			op_carry_circular_right: begin
				res_d = {8'h00, cin, a8[7:1]};
				flags_d[`ALSU_FLAG_C] = a8[0];
			end
			default: illegal_d = 1'b1;
		endcase
		// Logic results clear overflow
		if (op_code inside {op_conjunction, op_disjunction, op_exclusive_disjunction, op_invert,
				op_logic_shift_left, op_logic_shift_right, op_circular_left, op_circular_right,
				op_carry_circular_left, op_carry_circular_right}) begin
			flags_d[`ALSU_FLAG_V] = 1'b0;
		end
		if (op_code == op_arith_shift_left) begin
			flags_d[`ALSU_FLAG_V] = a8[7] ^ a8[6];
		end
		// Zero and negative from the value produced
		if (!diverr_d) begin
			flags_d[`ALSU_FLAG_Z] = word_d ? (res_d == 16'h0000) : (res_d[7:0] == 8'h00);
			flags_d[`ALSU_FLAG_N] = word_d ? res_d[15] : res_d[7];
			if (op_code == op_compare && !op_word) begin
				flags_d[`ALSU_FLAG_Z] = (s9[7:0] == 8'h00);
				flags_d[`ALSU_FLAG_N] = s9[7];
			end
			if (op_code == op_unsigned_divide) begin
				flags_d[`ALSU_FLAG_Z] = (quo[7:0] == 8'h00);
				flags_d[`ALSU_FLAG_N] = quo[7];
			end
		end
		if (illegal_d) begin
			wr_d    = 1'b0;
			flags_d = flags_q;
		end
	end

	// Result stage: one cycle from request to write-back
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			res_valid_q <= 1'b0;
			res_write_q <= 1'b0;
			res_word_q  <= 1'b0;
			res_q       <= 16'h0000;
			illegal_q   <= 1'b0;
		end else begin
			res_valid_q <= op_valid && !illegal_d;
			res_write_q <= op_valid && wr_d;
			illegal_q   <= op_valid && illegal_d;
			if (op_valid) begin
				res_word_q <= word_d;
				res_q      <= res_d;
			end
		end
	end

	// Condition flags; an operation outranks a software write in the same cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= `ALSU_FLAGS_RST;
		end else if (op_valid) begin
			flags_q <= flags_d;
		end else if (reg_wr && reg_addr == `ALSU_OFS_FLAGS) begin
			flags_q <= reg_wdata[`ALSU_FLAG_W-1:0];
		end
	end

	// Sticky status; a new event wins over a clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_q <= `ALSU_STAT_RST;
		end else begin
			if (reg_wr && reg_addr == `ALSU_OFS_STATUS) begin
				stat_q <= stat_q & ~reg_wdata[1:0];
			end
			if (op_valid && illegal_d) begin
				stat_q[`ALSU_STAT_ILLEGAL] <= 1'b1;
			end
			if (op_valid && diverr_d) begin
				stat_q[`ALSU_STAT_DIVERR] <= 1'b1;
			end
		end
	end

	// Read data stand for one cycle only
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 8'h00;
		end else if (!reg_rd) begin
			rdata_q <= 8'h00;
		end else if (reg_addr == `ALSU_OFS_FLAGS) begin
			rdata_q <= {3'h0, flags_q};
		end else if (reg_addr == `ALSU_OFS_STATUS) begin
			rdata_q <= {6'h00, stat_q};
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign res_valid  = res_valid_q;
	assign res_write  = res_write_q;
	assign res_word   = res_word_q;
	assign res_data   = res_q;
	assign op_illegal = illegal_q;
	assign cond_flags = flags_q;
	assign reg_rdata  = rdata_q;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_issue_step_up;
		op_valid && op_code == op_step_up;
	endsequence
	sequence s_issue_rcl;
		op_valid && op_code == op_carry_circular_left;
	endsequence

	a_step_up_value: assert property (s_issue_step_up |=> res_write && res_data[7:0] == $past(dst_val[7:0]) + 8'h01)
		else $error("step up result wrong");
	a_rcl_ring: assert property (s_issue_rcl |=> res_data[0] == $past(cin) && cond_flags[0] == $past(dst_val[7]))
		else $error("carry rotate ring broken");
	a_sub_imm_refused: assert property (op_valid && op_code == op_difference && op_imm |=> op_illegal && !res_write)
		else $error("immediate subtract accepted");
	a_word_imm_refused: assert property (op_valid && op_word && op_imm && op_code inside {op_sum, op_compare}
		|=> op_illegal && $stable(cond_flags))
		else $error("word immediate accepted");
	a_compare_nowrite: assert property (op_valid && op_code == op_compare && !op_imm |=> res_valid && !res_write)
		else $error("compare wrote a register");
	a_multiply_value: assert property (op_valid && op_code == op_unsigned_multiply
		|=> res_data == $past(dst_val[7:0]) * $past(src_val[7:0]) && res_word)
		else $error("product wrong");
	a_negate_value: assert property (op_valid && op_code == op_twos_complement
		|=> res_data[7:0] == 8'h00 - $past(dst_val[7:0]))
		else $error("negate wrong");
	a_sign_kept: assert property (op_valid && op_code == op_arith_shift_right
		|=> res_data[7] == res_data[6] && cond_flags[0] == $past(dst_val[0]))
		else $error("arithmetic right shift lost sign");
	a_zero_flag: assert property (op_valid && op_code == op_invert
		|=> cond_flags[2] == (res_data[7:0] == 8'h00) && cond_flags[3] == res_data[7])
		else $error("zero or negative flag wrong");
	a_carry_used: assert property (op_valid && op_code == op_sum_with_carry && op_imm
		|=> res_data[7:0] == 8'($past(dst_val[7:0]) + $past(imm_val) + {7'h00, $past(cin)}))
		else $error("carry not added");
	a_result_next: assert property (op_valid ##1 !op_illegal |-> res_valid ##1 !res_valid || $past(op_valid))
		else $error("result not one cycle after request");

endmodule

// ==== verif/alsu_rf_model.sv ====
// Register file stand-in that feeds operands and takes results back
module alsu_rf_model (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// Loading from the bench
	input  wire logic        ld,
	input  wire logic [15:0] ld_dst,
	input  wire logic [15:0] ld_src,
	// Result from the unit
	input  wire logic        res_write,
	input  wire logic        res_word,
	input  wire logic [15:0] res_data,
	// Operands to the unit
	output logic      [15:0] dst_q,
	output logic      [15:0] src_q
);
	timeunit 1ns;
	timeprecision 1ns;

	// Write back; a byte result leaves the high byte alone, as a real file would
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			dst_q <= 16'h0000;
			src_q <= 16'h0000;
		end else if (ld) begin
			dst_q <= ld_dst;
			src_q <= ld_src;
		end else if (res_write) begin
			dst_q <= res_word ? res_data : {dst_q[15:8], res_data[7:0]};
		end
	end
endmodule

// ==== verif/tb_cpu_arith_logic_shift_unit.sv ====
// Self-checking bench for the arithmetic, logic and shift unit
module tb_cpu_arith_logic_shift_unit
	import alsu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic        ill;
		logic        wr;
		logic        wd;
		logic        ckc;
		logic        c;
		logic        ckv;
		logic        v;
		logic        zn;
		logic        z;
		logic        n;
		logic [15:0] r;
	} alsu_exp_t;

	// Bench signals
	logic        core_clk, arst_n, op_valid, op_word, op_imm, op_step_two, ld;
	alsu_op_t    op_code, rc;
	logic [15:0] dst_val, src_val, ld_dst, ld_src, res_data, rd_v, rs_v;
	logic [7:0]  imm_val, reg_wdata, reg_rdata;
	logic [1:0]  reg_addr;
	logic        reg_wr, reg_rd, res_valid, res_write, res_word, op_illegal, rw, ri;
	logic [4:0]  cond_flags;
	int          mismatches, n_tests;

	alsu_unit u_alsu_unit (.core_clk(core_clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
		.op_word(op_word), .op_imm(op_imm), .op_step_two(op_step_two), .dst_val(dst_val), .src_val(src_val),
		.imm_val(imm_val), .res_valid(res_valid), .res_write(res_write), .res_word(res_word),
		.res_data(res_data), .op_illegal(op_illegal), .cond_flags(cond_flags), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	alsu_rf_model u_alsu_rf_model (.core_clk(core_clk), .arst_n(arst_n), .ld(ld), .ld_dst(ld_dst),
		.ld_src(ld_src), .res_write(res_write), .res_word(res_word), .res_data(res_data),
		.dst_q(dst_val), .src_q(src_val));

	// 10 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Expected outcome of one operation, with carry and half carry from f
	function automatic alsu_exp_t expect_op(input alsu_op_t c, input logic w, i, t, input logic [15:0] d, s,
		input logic [7:0] m, input logic [4:0] f);
		alsu_exp_t   e;
		logic [16:0] x;
		logic [15:0] dd, ss;
		logic        sb;
		dd = w ? d : {8'h00, d[7:0]};
		ss = w ? s : {8'h00, (i ? m : s[7:0])};
		e = '{1'b0, 1'b1, w, 1'b1, f[0], 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000};
		x = 17'h00000;
		case (c)
			op_sum, op_sum_with_carry: x = dd + ss + (c == op_sum_with_carry ? f[0] : 1'b0);
			op_difference, op_compare, op_difference_with_borrow: x = dd - ss - (c == op_difference_with_borrow ? f[0] : 1'b0);
			op_step_up: x = dd + 1;
			op_step_down: x = dd - 1;
			op_sum_one_or_two: {e.wd, x} = {1'b1, 17'(d + (t ? 2 : 1))};
			op_difference_one_or_two: {e.wd, x} = {1'b1, 17'(d - (t ? 2 : 1))};
			op_decimal_fix_after_sum: begin
				x = dd + ((f[4] || d[3:0] > 4'h9) ? 6 : 0) + ((f[0] || d[7:0] > 8'h99) ? 8'h60 : 0);
				e.c = f[0] || d[7:0] > 8'h99;
			end
			op_decimal_fix_after_difference: x = dd - (f[4] ? 6 : 0) - (f[0] ? 8'h60 : 0);
			op_unsigned_multiply: begin
				{e.wd, e.ckv, e.v} = {2'h3, f[1]};
				x = d[7:0] * s[7:0];
			end
			op_unsigned_divide: begin
				{e.wd, e.ckc, e.ckv} = 3'h5;
				if (s[7:0] == 8'h00 || d / s[7:0] > 255)
					{e.wr, e.v, e.zn} = 3'h2;
				else
					x = {1'b0, 8'(d % s[7:0]), 8'(d / s[7:0])};
			end
			op_twos_complement: {e.ckc, x} = {1'b0, 17'(0 - dd)};
			op_conjunction: {e.ckc, e.ckv, x} = {2'h1, 1'b0, dd & ss};
			op_disjunction: {e.ckc, e.ckv, x} = {2'h1, 1'b0, dd | ss};
			op_exclusive_disjunction: {e.ckc, e.ckv, x} = {2'h1, 1'b0, dd ^ ss};
			op_invert: {e.ckc, e.ckv, x} = {2'h1, 1'b0, ~dd};
			op_arith_shift_left: {e.ckv, e.v, e.c, x} = {1'b1, d[7] ^ d[6], d[7], 9'h0, d[6:0], 1'b0};
			op_arith_shift_right: {e.c, x} = {d[0], 9'h0, d[7], d[7:1]};
			op_logic_shift_left: {e.ckv, e.c, x} = {1'b1, d[7], 9'h0, d[6:0], 1'b0};
			op_logic_shift_right: {e.ckv, e.c, x} = {1'b1, d[0], 10'h0, d[7:1]};
			op_circular_left: {e.ckv, e.c, x} = {1'b1, d[7], 9'h0, d[6:0], d[7]};
			op_circular_right: {e.ckv, e.c, x} = {1'b1, d[0], 9'h0, d[0], d[7:1]};
			op_carry_circular_left: {e.ckv, e.c, x} = {1'b1, d[7], 9'h0, d[6:0], f[0]};
			default: {e.ckv, e.c, x} = {1'b1, d[0], 9'h0, f[0], d[7:1]};
		endcase
		// Overflow when operand signs agree (add) or differ (subtract) and the result sign flips
		if (c inside {op_sum, op_difference, op_compare, op_sum_with_carry, op_difference_with_borrow}) begin
			sb = c inside {op_difference, op_compare, op_difference_with_borrow};
			e.c = e.wd ? x[16] : x[8];
			e.ckv = 1'b1;
			e.v = ((e.wd ? dd[15] ^ ss[15] : dd[7] ^ ss[7]) == sb) && (e.wd ? x[15] != dd[15] : x[7] != dd[7]);
		end
		e.ill = (w && i && c != op_difference) || (i && c == op_difference);
		e.wr = e.wr && !e.ill && c != op_compare;
		e.r = e.wd ? x[15:0] : {8'h00, x[7:0]};
		{e.z, e.n} = e.wd ? {x[15:0] == 16'h0000, x[15]} : {x[7:0] == 8'h00, x[7]};
		if (c == op_unsigned_divide)
			{e.z, e.n} = {x[7:0] == 8'h00, x[7]};
		return e;
	endfunction

	// Load operands and flags, issue one op, then check result and write-back
	task automatic run_op(input alsu_op_t c, input logic w, i, t, input logic [15:0] d, s,
		input logic [7:0] m, input logic [4:0] f);
		alsu_exp_t e;
		e = expect_op(c, w, i, t, d, s, m, f);
		{ld, ld_dst, ld_src, reg_wr, reg_addr, reg_wdata} <= {1'b1, d, s, 1'b1, 2'h0, 3'h0, f};
		@(posedge core_clk);
		{ld, reg_wr, op_valid, op_word, op_imm, op_step_two, imm_val} <= {3'h1, w, i, t, m};
		op_code <= c;
		@(posedge core_clk);
		op_valid <= 1'b0;
		#1;
		chk(op_illegal, e.ill);
		chk(res_valid, !e.ill);
		chk(res_write, e.wr);
		if (e.ill)
			chk(cond_flags, f);
		if (e.wr)
			chk(res_data, e.r);
		if (e.wr)
			chk(res_word, e.wd);
		if (!e.ill && e.zn)
			chk({cond_flags[3], cond_flags[2]}, {e.n, e.z});
		if (!e.ill && e.ckc)
			chk(cond_flags[0], e.c);
		if (!e.ill && e.ckv)
			chk(cond_flags[1], e.v);
		@(posedge core_clk);
		#1;
		chk(dst_val, e.wr ? (e.wd ? e.r : {d[15:8], e.r[7:0]}) : d);
		@(posedge core_clk);
	endtask

	task automatic reg_access(input logic wr, input logic [1:0] a, input logic [7:0] wd, exp);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, wd};
		@(posedge core_clk);
		{reg_wr, reg_rd} <= 2'h0;
		#1;
		if (!wr)
			chk(reg_rdata, exp);
		@(posedge core_clk);
		#1;
		chk(reg_rdata, 8'h00);
		@(posedge core_clk);
	endtask

	// Hang guard
	initial begin
		#2000000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		{arst_n, op_valid, op_word, op_imm, op_step_two, ld, reg_wr, reg_rd} = 8'h00;
		op_code = op_sum;
		{imm_val, ld_dst, ld_src, reg_addr, reg_wdata} = '0;
		{mismatches, n_tests} = 0;
		void'($urandom(32'hd71857fa));
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		reg_access(1'b0, 2'h0, 8'h00, 8'h00);
		reg_access(1'b0, 2'h1, 8'h00, 8'h00);
		reg_access(1'b1, 2'h2, 8'hff, 8'h00);
		reg_access(1'b0, 2'h2, 8'h00, 8'h00);
		run_op(op_step_up, 1'b0, 1'b0, 1'b0, 16'h007f, 16'h0000, 8'h00, 5'h00);
		// Every code once on boundary operands
		for (int k = 0; k < 26; k++)
			run_op(alsu_op_t'(k), 1'b0, 1'b0, 1'b1, 16'h80ff, 16'h0001, 8'h01, 5'h11);
		run_op(op_unsigned_divide, 1'b0, 1'b0, 1'b0, 16'h1234, 16'h0056, 8'h00, 5'h00);
		run_op(op_unsigned_divide, 1'b0, 1'b0, 1'b0, 16'h1234, 16'h0000, 8'h00, 5'h00);
		run_op(op_sum, 1'b1, 1'b0, 1'b0, 16'hffff, 16'h0001, 8'h00, 5'h00);
		run_op(op_difference, 1'b0, 1'b1, 1'b0, 16'h0010, 16'h0001, 8'h05, 5'h00);
		reg_access(1'b0, 2'h1, 8'h00, 8'h03);
		reg_access(1'b1, 2'h1, 8'h03, 8'h00);
		reg_access(1'b0, 2'h1, 8'h00, 8'h00);
		// Carry of one op feeds the op issued right behind it
		{ld, ld_dst, ld_src, reg_wr, reg_addr, reg_wdata} <= {1'b1, 16'h00ff, 16'h0001, 1'b1, 2'h0, 8'h00};
		@(posedge core_clk);
		{ld, reg_wr, op_valid, op_word, op_imm} <= {3'h1, 2'h0};
		op_code <= op_sum;
		@(posedge core_clk);
		op_code <= op_sum_with_carry;
		@(posedge core_clk);
		op_valid <= 1'b0;
		#1;
		chk(res_data, 16'h0001);
		@(posedge core_clk);
		#1;
		chk(dst_val, 16'h0001);
		@(posedge core_clk);
		// Random traffic
		for (int k = 0; k < 300; k++) begin
			rc = alsu_op_t'($urandom % 26);
			rw = (rc inside {op_sum, op_difference, op_compare}) ? 1'($urandom) : 1'b0;
			ri = (rc inside {op_sum, op_difference, op_compare, op_sum_with_carry, op_difference_with_borrow,
				op_conjunction, op_disjunction, op_exclusive_disjunction}) ? 1'($urandom) : 1'b0;
			rd_v = 16'($urandom);
			rs_v = 16'($urandom);
			if (rc == op_unsigned_divide && rs_v[7:0] != 8'h00 && $urandom % 2 == 0)
				rd_v[15:8] = rd_v[15:8] % rs_v[7:0];
			run_op(rc, rw, ri, 1'($urandom), rd_v, rs_v, 8'($urandom), 5'($urandom));
		end
		report_and_stop();
	end
endmodule
